// File: pin_interface_cell.sv
// Configurable registered pin interface cell with APB configuration slave
`timescale 1ns/1ps
`default_nettype none
module pin_interface_cell (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   config_done,
   input  wire logic                   mode_pullup,
   input  wire logic                   cell_clk,
   input  wire logic                   shared_set_reset,
   input  wire logic [2:0]             cell_ce,
   input  wire logic                   core_out,
   input  wire logic                   core_oe,
   output logic                        core_in,
   input  wire logic                   pad_in,
   output logic                        pad_out,
   output logic                        pad_oe,
   output logic                        pull_up,
   output logic                        pull_down,
   output logic                        keep_out,
   output logic                        keep_oe,
   input  wire pin_cell_pkg::scan_ctl_t scan,
   output logic                        tdo
);

   pin_cell_pkg::cell_state_t r;
   pin_cell_pkg::cell_state_t next_r;

   // Address decode for the error response; the write path decodes paddr itself
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == pin_cell_pkg::OFF_STORE) || (a == pin_cell_pkg::OFF_INVERT) ||
               (a == pin_cell_pkg::OFF_PAD) || (a == pin_cell_pkg::OFF_STATUS);
   endfunction

   logic       clk_lvl;
   logic       rise;
   logic       sr_act;
   logic [2:0] ce;
   logic [2:0] d;
   logic [2:0] eff;
   logic [2:0] is_async;
   logic [2:0] init;
   logic [2:0] transp;
   logic       oe_core;
   logic       out_val;
   logic       oe_val;
   logic [31:0] status;
   logic       setup;
   logic       wr;

   // Control inputs each pass their own inverter
   // polarity inversion
   assign clk_lvl = cell_clk ^ r.invert[pin_cell_pkg::IV_CLK];
   assign sr_act  = shared_set_reset ^ r.invert[pin_cell_pkg::IV_SR];
   assign ce      = cell_ce ^ r.invert[pin_cell_pkg::IV_CE +: 3];
   assign oe_core = core_oe ^ r.invert[pin_cell_pkg::IV_OE];
   assign rise = clk_lvl & ~r.clk_prev;

   // Data inputs of the three elements
   // optional delay stage
   assign d[pin_cell_pkg::EL_IN]  = r.store[pin_cell_pkg::ST_DELAY] ? r.dly : pad_in;
   assign d[pin_cell_pkg::EL_OUT] = core_out;
   assign d[pin_cell_pkg::EL_OE]  = oe_core;

   // Per-element view; a latch is transparent while its clock level and enable are high
   genvar gi;
   generate
      for (gi = 0; gi < pin_cell_pkg::NUM_EL; gi++) begin : g_el
         logic [1:0] mode;
         assign mode = r.store[pin_cell_pkg::ST_SRMODE + 2*gi +: 2];
         assign is_async[gi] = mode[1];
         assign init[gi]     = mode[0];
         assign transp[gi] = r.store[pin_cell_pkg::ST_LATCH + gi] & clk_lvl & ce[gi];
         // async force acts without an edge
         assign eff[gi] = (is_async[gi] & sr_act) ? init[gi] :
                          transp[gi] ? (sr_act ? init[gi] : d[gi]) : r.q[gi];
      end
   endgenerate

   // Bypass selection for each path
   // input bypass
   assign core_in = r.store[pin_cell_pkg::ST_USEREG + pin_cell_pkg::EL_IN] ?
                    eff[pin_cell_pkg::EL_IN] : pad_in;
   assign out_val = (r.store[pin_cell_pkg::ST_USEREG + pin_cell_pkg::EL_OUT] ?
                     eff[pin_cell_pkg::EL_OUT] : core_out) ^ r.invert[pin_cell_pkg::IV_OUT];
   assign oe_val = r.store[pin_cell_pkg::ST_USEREG + pin_cell_pkg::EL_OE] ?
                   eff[pin_cell_pkg::EL_OE] : oe_core;

   // Pad drive; scan update overrides the core during external test
   // high impedance before configuration
   always_comb begin
      if (!config_done) begin
         pad_out = 1'b0;
         pad_oe  = 1'b0;
      end else if (scan.extest) begin
         pad_out = r.scan_hold[pin_cell_pkg::EL_OUT];
         pad_oe  = r.scan_hold[pin_cell_pkg::EL_OE];
      end else begin
         pad_out = out_val;
         pad_oe  = oe_val;
      end
   end

   // Pull resistors and keeper
   // global pull-up before configuration
   assign pull_up   = config_done ? r.pad[pin_cell_pkg::PD_PULLUP] : mode_pullup;
   assign pull_down = config_done & r.pad[pin_cell_pkg::PD_PULLDOWN];
   // weak hold of the last level
   assign keep_oe   = config_done & r.pad[pin_cell_pkg::PD_KEEPER] & ~pad_oe;
   assign keep_out  = r.kept;

   // Status word
   always_comb begin
      status = 32'h0000_0000;
      status[pin_cell_pkg::SS_PAD] = pad_in;
      status[pin_cell_pkg::SS_Q +: 3] = eff;
      status[pin_cell_pkg::SS_DONE] = config_done;
      status[pin_cell_pkg::SS_KEPT] = r.kept;
   end

   // APB phases; the slave never stalls
   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign prdata  = r.prdata;
   assign pslverr = r.pslverr;
   assign tdo     = r.scan_shift[0];

   // Next state
   always_comb begin
      next_r = r;
      next_r.clk_prev = clk_lvl;
      // One pclk of delay stands in for the clock distribution delay
      next_r.dly = pad_in;
      // The keeper follows the pad on every pclk, whatever drives it
      next_r.kept = pad_in;
      for (int i = 0; i < pin_cell_pkg::NUM_EL; i++) begin
         if (is_async[i] & sr_act) begin
            next_r.q[i] = init[i];
         end else if (r.store[pin_cell_pkg::ST_LATCH + i]) begin
            next_r.q[i] = eff[i];
         end else if (rise & sr_act) begin
            // sync force only at an edge
            next_r.q[i] = init[i];
         end else if (rise & ce[i]) begin
            next_r.q[i] = d[i];
         end
      end
      if (scan.capture) begin
         next_r.scan_shift = {oe_val, out_val, pad_in};
      end else if (scan.shift) begin
         next_r.scan_shift = {scan.tdi, r.scan_shift[2:1]};
      end
      if (scan.update) begin
         next_r.scan_hold = r.scan_shift;
      end
      // Read data is latched in the setup cycle so it is steady in the access cycle
      if (setup) begin
         next_r.pslverr = ~mapped(paddr);
         case (paddr)
            pin_cell_pkg::OFF_STORE:  next_r.prdata = r.store;
            pin_cell_pkg::OFF_INVERT: next_r.prdata = r.invert;
            pin_cell_pkg::OFF_PAD:    next_r.prdata = r.pad;
            pin_cell_pkg::OFF_STATUS: next_r.prdata = status;
            default:                  next_r.prdata = 32'h0000_0000;
         endcase
      end
      // Writes take effect in the access cycle; status is read only
      if (wr) begin
         case (paddr)
            pin_cell_pkg::OFF_STORE:  next_r.store = {19'h0, pwdata[12:0]};
            pin_cell_pkg::OFF_INVERT: next_r.invert = {25'h0, pwdata[6:0]};
            pin_cell_pkg::OFF_PAD:    next_r.pad = {29'h0, pwdata[2:0]};
            default:                  next_r.pad = r.pad;
         endcase
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.store <= pin_cell_pkg::RST_STORE;
         r.invert <= pin_cell_pkg::RST_INVERT;
         r.pad <= pin_cell_pkg::RST_PAD;
      end else begin
         r <= next_r;
      end
   end

endmodule // pin_interface_cell
`default_nettype wire

// File: pin_cell_pkg.sv
// Constants, field layout and types for the configurable pin interface cell
package pin_cell_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_STORE  = 8'h00;
   localparam logic [7:0] OFF_INVERT = 8'h04;
   localparam logic [7:0] OFF_PAD    = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;

   // Element indices
   localparam int EL_IN  = 0;
   localparam int EL_OUT = 1;
   localparam int EL_OE  = 2;
   localparam int NUM_EL = 3;

   // Storage register fields
   localparam int ST_LATCH = 0;   // [2:0] one per element, 1 = latch
   localparam int ST_SRMODE = 3;  // [8:3] two bits per element
   localparam int ST_USEREG = 9;  // [11:9] one per element, 1 = through element
   localparam int ST_DELAY = 12;

   // Inversion register fields
   localparam int IV_OUT = 0;
   localparam int IV_CLK = 1;
   localparam int IV_SR = 2;
   localparam int IV_CE = 3;      // [5:3] one per element
   localparam int IV_OE = 6;

   // Pad register fields
   localparam int PD_PULLUP = 0;
   localparam int PD_PULLDOWN = 1;
   localparam int PD_KEEPER = 2;

   // Status register fields
   localparam int SS_PAD = 0;
   localparam int SS_Q = 1;       // [3:1]
   localparam int SS_DONE = 4;
   localparam int SS_KEPT = 5;

   // Reset values
   localparam logic [31:0] RST_STORE  = 32'h0000_0000;
   localparam logic [31:0] RST_INVERT = 32'h0000_0000;
   localparam logic [31:0] RST_PAD    = 32'h0000_0000;

   // Shared set/reset behaviour; bit 0 gives the forced value, bit 1 async
   typedef enum logic [1:0] {
      SR_SYNC_RESET  = 2'b00,
      SR_SYNC_SET    = 2'b01,
      SR_ASYNC_CLEAR = 2'b10,
      SR_ASYNC_SET   = 2'b11
   } sr_mode_t;

   // Boundary-scan controls from the test access port
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
      logic extest;
      logic tdi;
   } scan_ctl_t;

   // Whole state of the cell
   typedef struct packed {
      logic [31:0] store;
      logic [31:0] invert;
      logic [31:0] pad;
      logic [2:0]  q;
      logic        clk_prev;
      logic        dly;
      logic        kept;
      logic [2:0]  scan_shift;
      logic [2:0]  scan_hold;
      logic [31:0] prdata;
      logic        pslverr;
   } cell_state_t;

endpackage

// File: cell_checker.sv
// Port assertions for the pin interface cell
`timescale 1ns/1ps
`default_nettype none
module cell_checker (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [7:0]    paddr,
   input wire logic [31:0]   pwdata,
   input wire logic          config_done,
   input wire logic          mode_pullup,
   input wire logic          shared_set_reset,
   input wire logic          core_out,
   input wire logic          core_oe,
   input wire logic          core_in,
   input wire logic          pad_in,
   input wire logic          pad_out,
   input wire logic          pad_oe,
   input wire logic          pull_up,
   input wire logic          pull_down,
   input wire logic          keep_out,
   input wire logic          keep_oe,
   input wire pin_cell_pkg::scan_ctl_t scan,
   input wire logic          tdo
);
   logic [12:0] st;
   logic [6:0]  iv;
   logic        sra;
   // Shadow of the written setup, so each check knows which path is live
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         iv <= '0;
      end else if (psel && penable && pwrite) begin
         if (paddr == 8'h00)
            st <= pwdata[12:0];
         if (paddr == 8'h04)
            iv <= pwdata[6:0];
      end
   end
   // Shared set/reset after its polarity choice
   assign sra = shared_set_reset ^ iv[2];
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_PRECFG_HIZ: assert property (!config_done |-> !pad_oe && !pull_down && !keep_oe)
      else $error("pin active before setup");
   AST_PRECFG_PULL: assert property (!config_done |-> pull_up == mode_pullup)
      else $error("pull-up not global");
   AST_KEEP_LAST: assert property (config_done && $past(presetn) |->
      keep_out == $past(pad_in)) else $error("keeper lost level");
   AST_TDO_SHIFT: assert property ((scan.shift && !scan.capture) [*3] |=>
      tdo == $past(scan.tdi, 3)) else $error("scan chain order wrong");
   AST_IN_DIRECT: assert property (config_done && !st[9] |-> core_in == pad_in)
      else $error("input bypass wrong");
   AST_OUT_DIRECT: assert property (config_done && !scan.extest && !st[10] |->
      pad_out == (core_out ^ iv[0])) else $error("output bypass wrong");
   AST_OE_DIRECT: assert property (config_done && !scan.extest && !st[11] |->
      pad_oe == (core_oe ^ iv[6])) else $error("enable bypass wrong");
   AST_ASYNC_SR: assert property (config_done && st[9] && st[4] && sra |->
      core_in == st[3]) else $error("async force late");
endmodule // cell_checker
bind pin_interface_cell cell_checker chk (.*);
`default_nettype wire

// File: board_pin.sv
// Board-side model of the signal wired to the pin
`timescale 1ns/1ps
`default_nettype none
module board_pin (
   input  wire logic pclk,
   input  wire logic drv_en,
   input  wire logic drv_val,
   input  wire logic pad_out,
   input  wire logic pad_oe,
   input  wire logic pull_up,
   input  wire logic pull_down,
   input  wire logic keep_out,
   input  wire logic keep_oe,
   output logic      pad_in
);
   logic flt = 1'b0;
   // An undriven wire wanders, so a stale level never passes
   always @(posedge pclk) begin
      flt <= ~flt;
   end
   assign pad_in = drv_en ? drv_val : pad_oe ? pad_out : keep_oe ? keep_out :
                   pull_up ? 1'b1 : pull_down ? 1'b0 : flt;
endmodule // board_pin
`default_nettype wire

// File: test_registered_io_cell.sv
// Self-checking bench for the pin interface cell
`timescale 1ns/1ps
`default_nettype none
module test_registered_io_cell;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        config_done, mode_pullup, cell_clk, shared_set_reset, core_out, core_oe;
   logic        core_in, pad_in, pad_out, pad_oe, pull_up, pull_down, keep_out, keep_oe;
   logic        tdo, drv_en, drv_val;
   logic [2:0]  cell_ce;
   pin_cell_pkg::scan_ctl_t scan;
   int          miscompares, cmp_count;
   pin_interface_cell dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .config_done, .mode_pullup, .cell_clk, .shared_set_reset,
      .cell_ce, .core_out, .core_oe, .core_in, .pad_in, .pad_out, .pad_oe, .pull_up,
      .pull_down, .keep_out, .keep_oe, .scan, .tdo);
   board_pin board (.pclk, .drv_en, .drv_val, .pad_out, .pad_oe, .pull_up, .pull_down,
      .keep_out, .keep_oe, .pad_in);
   // Compare and count
   task automatic check(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One bus transfer; waits for pready rather than counting cycles
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Cell clock pulse, wide enough for the sampled edge
   task automatic tick();
      cell_clk <= 1'b1;
      repeat (3) @(posedge pclk);
      cell_clk <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic t_precfg();
      core_oe <= 1'b1;
      mode_pullup <= 1'b1;
      @(posedge pclk);
      check("pre oe", 32'({pad_oe, pull_down, keep_oe}), 32'h0);
      check("pre pull", 32'({pull_up, pad_in}), 32'h3);
      apb(1'b0, 8'h00, 32'h0);
      check("reset store", rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped", 32'(rerr), 32'h1);
   endtask
   task automatic t_out();
      config_done <= 1'b1;
      core_oe <= 1'b0;
      apb(1'b1, 8'h04, 32'h0000_0041);
      core_out <= 1'b1;
      @(posedge pclk);
      check("inverted", 32'({pad_oe, pad_out, pad_in}), 32'h4);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h00, 32'h0000_0c00);
      core_oe <= 1'b1;
      cell_ce <= 3'b010;
      @(posedge pclk);
      check("held", 32'({pad_oe, pad_out}), 32'h0);
      tick();
      check("own ce", 32'({pad_oe, pad_out}), 32'h1);
      cell_ce <= 3'b100;
      tick();
      check("timed oe", 32'(pad_oe), 32'h1);
      core_oe <= 1'b0;
   endtask
   task automatic t_in();
      apb(1'b1, 8'h00, 32'h0000_1210);
      drv_en <= 1'b1;
      drv_val <= 1'b1;
      cell_ce <= 3'b001;
      tick();
      check("captured", 32'(core_in), 32'h1);
      shared_set_reset <= 1'b1;
      @(posedge pclk);
      check("async clr", 32'(core_in), 32'h0);
      apb(1'b1, 8'h00, 32'h0000_0208);
      drv_val <= 1'b0;
      cell_ce <= 3'b000;
      check("no edge", 32'(core_in), 32'h0);
      tick();
      check("sync set", 32'(core_in), 32'h1);
      shared_set_reset <= 1'b0;
      // Input element as a latch: follows the pin while open, holds once shut
      apb(1'b1, 8'h00, 32'h0000_0201);
      cell_ce <= 3'b001;
      cell_clk <= 1'b1;
      drv_val <= 1'b1;
      @(posedge pclk);
      check("latch open", 32'(core_in), 32'h1);
      cell_clk <= 1'b0;
      @(posedge pclk);
      drv_val <= 1'b0;
      @(posedge pclk);
      check("latch shut", 32'(core_in), 32'h1);
   endtask
   task automatic t_keep();
      apb(1'b1, 8'h08, 32'h0000_0004);
      for (int v = 0; v < 2; v++) begin
         drv_val <= 1'(v);
         drv_en <= 1'b1;
         repeat (2) @(posedge pclk);
         drv_en <= 1'b0;
         repeat (3) @(posedge pclk);
         check("kept", 32'(pad_in), 32'(v));
      end
      apb(1'b1, 8'h08, 32'h0000_0001);
      check("pulls", 32'({pull_up, pull_down}), 32'h2);
      apb(1'b1, 8'h08, 32'h0000_0002);
      check("pull down", 32'({pull_up, pull_down, pad_in}), 32'h2);
   endtask
   task automatic t_scan();
      for (int i = 0; i < 6; i++) begin
         scan <= {4'b0100, 1'(i != 2)};
         @(posedge pclk);
         if (i >= 3)
            check("tdo", 32'(tdo), 32'(i != 5));
      end
      scan <= 5'b00110;
      repeat (2) @(posedge pclk);
      check("extest", 32'({pad_oe, pad_out}), 32'h3);
      scan <= '0;
   endtask
   // Free-running bus clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Cuts a hang short
   initial begin
      #200us;
      miscompares++;
      conclude();
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, config_done, mode_pullup} = '0;
      {cell_clk, shared_set_reset, cell_ce, core_out, core_oe, scan, drv_en, drv_val} = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_precfg();
      t_out();
      t_in();
      t_keep();
      t_scan();
      conclude();
   end
endmodule // test_registered_io_cell
`default_nettype wire
